// File: common/ucr_pkg.sv
// ucr_pkg: constants and carriers for the per-channel serial register bank
// assumes a byte-wide host register port decoded from address bits 11:9 and 3:0
package ucr_pkg;
    localparam int UCR_CHANNELS = 4;
    localparam int UCR_ADDR_W = 12;
    localparam int UCR_CH_LSB = 9;
    localparam int UCR_CH_MSB = 11;
    localparam int UCR_REG_LSB = 0;
    localparam int UCR_REG_MSB = 3;
    // register offsets
    localparam logic [3:0] UCR_OFS_HOLD = 4'h0;
    localparam logic [3:0] UCR_OFS_IEN = 4'h1;
    localparam logic [3:0] UCR_OFS_ISTAT = 4'h2;
    localparam logic [3:0] UCR_OFS_LCTL = 4'h3;
    localparam logic [3:0] UCR_OFS_MCTL = 4'h4;
    localparam logic [3:0] UCR_OFS_LSTAT = 4'h5;
    localparam logic [3:0] UCR_OFS_MSTAT = 4'h6;
    localparam logic [3:0] UCR_OFS_SCRATCH = 4'h7;
    localparam logic [3:0] UCR_OFS_FEAT = 4'h8;
    localparam logic [3:0] UCR_OFS_ENH = 4'h9;
    localparam logic [3:0] UCR_OFS_TXQ = 4'ha;
    localparam logic [3:0] UCR_OFS_RXQ = 4'hb;
    localparam logic [3:0] UCR_OFS_FLOW = 4'hc;
    localparam logic [3:0] UCR_OFS_PAUSE2 = 4'hd;
    localparam logic [3:0] UCR_OFS_RESUME1 = 4'he;
    localparam logic [3:0] UCR_OFS_RESUME2 = 4'hf;
    // field positions and masks
    localparam int UCR_LCTL_DIVEN = 7;
    localparam int UCR_ENH_EXTEN = 4;
    localparam int UCR_FLOW_RESUME = 1;
    localparam int UCR_FLOW_PAUSE = 0;
    localparam int UCR_MCTL_GPO1 = 2;
    localparam int UCR_MCTL_GPO2 = 3;
    localparam int UCR_DLY_LSB = 4;
    localparam logic [7:0] UCR_IEN_EXT_MASK = 8'hE0;
    localparam logic [7:0] UCR_ISTAT_EXT_MASK = 8'h30;
    localparam logic [7:0] UCR_QCTL_EXT_MASK = 8'h30;
    localparam logic [7:0] UCR_MCTL_EXT_MASK = 8'hE4;
    localparam logic [7:0] UCR_MSTAT_EXT_MASK = 8'hF0;
    localparam logic [7:0] UCR_IEN_RSV_MASK = 8'h10;
    localparam logic [7:0] UCR_ZERO8 = 8'h00;
    localparam logic [7:0] UCR_LCTL_RST = 8'h00;

    // host register access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [UCR_ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } ucr_req_t;

    // status fed in from the serial core of one channel
    typedef struct packed {
        logic [7:0] rx_data;
        logic [7:0] istat;
        logic [7:0] lstat;
        logic [7:0] mstat;
        logic [7:0] tx_level;
        logic [7:0] rx_level;
        logic resume_seen;
        logic pause_seen;
    } ucr_stat_t;

    // configuration driven out to the serial core of one channel
    typedef struct packed {
        logic [15:0] divisor;
        logic [7:0] ien;
        logic [7:0] qctl;
        logic [7:0] lctl;
        logic [7:0] mctl;
        logic [7:0] feat;
        logic [7:0] enh;
        logic [3:0] turnaround;
        logic [7:0] tx_thresh;
        logic [7:0] rx_thresh;
        logic [7:0] pause1;
        logic [7:0] pause2;
        logic [7:0] resume1;
        logic [7:0] resume2;
    } ucr_cfg_t;
endpackage

// File: design/ucr_bank.sv
// ucr_bank: host-visible register bank for four serial channels
// assumes host requests are synchronous to clk_sys_in, one cycle each
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - extended upper bits need enhanced-function bit 4
// - general outputs drive no external pin
// - general outputs kept as read/write storage, gpo1 writable only with enhanced-function bit 4
// - flow flags: resume bit1, pause bit0, clear-on-read
// - low four address bits select sixteen registers
// - divisor bytes reachable only with divisor-enable set
// - address bits 11:9 select channel 0..3
module ucr_bank
    import ucr_pkg::*;
#(
    parameter int CHANNELS = UCR_CHANNELS
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // host register port
    input wire ucr_req_t req_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    // per-channel core side
    input wire ucr_stat_t [CHANNELS-1:0] stat_in,
    output ucr_cfg_t [CHANNELS-1:0] cfg_out,
    output logic [CHANNELS-1:0] tx_push_out,
    output logic [CHANNELS-1:0] rx_pop_out,
    output logic [7:0] tx_data_out
);
    logic [2:0] ch_sel;
    logic [3:0] ofs;
    logic ch_ok;
    logic [7:0] next_rdata;
    logic [7:0] rdata;
    logic rvalid;
    logic [CHANNELS-1:0] tx_push;
    logic [CHANNELS-1:0] rx_pop;
    logic [7:0] tx_data;
    logic [CHANNELS-1:0] resume_flag;
    logic [CHANNELS-1:0] pause_flag;
    ucr_cfg_t [CHANNELS-1:0] cfg;

    assign ch_sel = req_in.addr[UCR_CH_MSB:UCR_CH_LSB];
    assign ofs = req_in.addr[UCR_REG_MSB:UCR_REG_LSB];
    // unmapped channels read as zero and ignore writes
    assign ch_ok = (int'(ch_sel) < CHANNELS);

    // per-channel write decode and storage
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        logic sel;
        logic wr;
        logic rd;
        logic dl;
        logic ext;
        assign sel = ch_ok && (int'(ch_sel) == c);
        assign wr = sel && req_in.wr;
        assign rd = sel && req_in.rd;
        assign dl = cfg[c].lctl[UCR_LCTL_DIVEN];
        assign ext = cfg[c].enh[UCR_ENH_EXTEN];

        always_ff @(posedge clk_sys_in or posedge rst_in) begin
            if (rst_in) begin
                cfg[c] <= '0;
            end else if (wr) begin
                unique case (ofs)
                    UCR_OFS_HOLD: begin
                        if (dl) begin
                            cfg[c].divisor[7:0] <= req_in.wdata;
                        end
                    end
                    UCR_OFS_IEN: begin
                        if (dl) begin
                            cfg[c].divisor[15:8] <= req_in.wdata;
                        end else if (ext) begin
                            cfg[c].ien <= req_in.wdata & ~UCR_IEN_RSV_MASK;
                        end else begin
                            cfg[c].ien <= req_in.wdata & ~(UCR_IEN_EXT_MASK
                                | UCR_IEN_RSV_MASK);
                        end
                    end
                    UCR_OFS_ISTAT: begin
                        if (ext) begin
                            cfg[c].qctl <= req_in.wdata;
                        end else begin
                            cfg[c].qctl <= req_in.wdata & ~UCR_QCTL_EXT_MASK;
                        end
                    end
                    UCR_OFS_LCTL: cfg[c].lctl <= req_in.wdata;
                    UCR_OFS_MCTL: begin
                        // general output bits stay plain storage for loopback
                        if (ext) begin
                            cfg[c].mctl <= req_in.wdata;
                        end else begin
                            // ext bits keep their old value while the enable is off
                            cfg[c].mctl <= (req_in.wdata & ~UCR_MCTL_EXT_MASK)
                                | (cfg[c].mctl & UCR_MCTL_EXT_MASK);
                        end
                    end
                    UCR_OFS_LSTAT: begin
                    end
                    UCR_OFS_MSTAT: begin
                        cfg[c].turnaround <= req_in.wdata[7:UCR_DLY_LSB];
                    end
                    UCR_OFS_SCRATCH: begin
                    end
                    UCR_OFS_FEAT: cfg[c].feat <= req_in.wdata;
                    UCR_OFS_ENH: cfg[c].enh <= req_in.wdata;
                    UCR_OFS_TXQ: cfg[c].tx_thresh <= req_in.wdata;
                    UCR_OFS_RXQ: cfg[c].rx_thresh <= req_in.wdata;
                    UCR_OFS_FLOW: cfg[c].pause1 <= req_in.wdata;
                    UCR_OFS_PAUSE2: cfg[c].pause2 <= req_in.wdata;
                    UCR_OFS_RESUME1: cfg[c].resume1 <= req_in.wdata;
                    UCR_OFS_RESUME2: cfg[c].resume2 <= req_in.wdata;
                endcase
            end
        end

        // scratch kept apart so the cfg carrier stays core-facing only
        logic [7:0] scratch;
        always_ff @(posedge clk_sys_in or posedge rst_in) begin
            if (rst_in) begin
                scratch <= UCR_ZERO8;
            end else if (wr && ofs == UCR_OFS_SCRATCH) begin
                scratch <= req_in.wdata;
            end
        end

        // flow flags: a detection in the read cycle survives the clear
        always_ff @(posedge clk_sys_in or posedge rst_in) begin
            if (rst_in) begin
                resume_flag[c] <= 1'b0;
                pause_flag[c] <= 1'b0;
            end else begin
                if (stat_in[c].resume_seen) begin
                    resume_flag[c] <= 1'b1;
                end else if (rd && ofs == UCR_OFS_FLOW) begin
                    resume_flag[c] <= 1'b0;
                end
                if (stat_in[c].pause_seen) begin
                    pause_flag[c] <= 1'b1;
                end else if (rd && ofs == UCR_OFS_FLOW) begin
                    pause_flag[c] <= 1'b0;
                end
            end
        end

        // holding register strobes go to the channel core for one cycle
        // pop only on a real read, so a divisor read never drains the queue
        always_ff @(posedge clk_sys_in or posedge rst_in) begin
            if (rst_in) begin
                tx_push[c] <= 1'b0;
                rx_pop[c] <= 1'b0;
            end else begin
                tx_push[c] <= wr && ofs == UCR_OFS_HOLD && !dl;
                rx_pop[c] <= rd && ofs == UCR_OFS_HOLD && !dl;
            end
        end

        // masked and real mctl: the general outputs never reach a pin
        always_comb begin
            cfg_out[c] = cfg[c];
            // gpo1 reaches the core only with the enhanced enable set
            cfg_out[c].mctl[UCR_MCTL_GPO1] = ext ? cfg[c].mctl[UCR_MCTL_GPO1]
                : 1'b0;
            if (!ext) begin
                cfg_out[c].ien = cfg[c].ien & ~UCR_IEN_EXT_MASK;
                cfg_out[c].qctl = cfg[c].qctl & ~UCR_QCTL_EXT_MASK;
                cfg_out[c].mctl = cfg[c].mctl & ~UCR_MCTL_EXT_MASK;
            end
        end
    end

    // read mux, evaluated on the request cycle
    always_comb begin
        logic [7:0] ext_m;
        ucr_cfg_t cf;
        ucr_stat_t st;
        int c;
        ext_m = UCR_ZERO8;
        cf = '0;
        st = '0;
        c = int'(ch_sel);
        next_rdata = UCR_ZERO8;
        if (ch_ok) begin
            cf = cfg[c];
            st = stat_in[c];
            ext_m = cf.enh[UCR_ENH_EXTEN] ? 8'hFF : UCR_ZERO8;
            unique case (ofs)
                UCR_OFS_HOLD: next_rdata = cf.lctl[UCR_LCTL_DIVEN]
                    ? cf.divisor[7:0] : st.rx_data;
                UCR_OFS_IEN: next_rdata = cf.lctl[UCR_LCTL_DIVEN]
                    ? cf.divisor[15:8] : (cf.ien & (~UCR_IEN_EXT_MASK | ext_m));
                UCR_OFS_ISTAT: next_rdata = st.istat
                    & (~UCR_ISTAT_EXT_MASK | ext_m);
                UCR_OFS_LCTL: next_rdata = cf.lctl;
                UCR_OFS_MCTL: next_rdata = cf.mctl;
                UCR_OFS_LSTAT: next_rdata = st.lstat;
                UCR_OFS_MSTAT: next_rdata = st.mstat
                    & (~UCR_MSTAT_EXT_MASK | ext_m);
                UCR_OFS_SCRATCH: next_rdata = g_scr_rd(c);
                UCR_OFS_FEAT: next_rdata = cf.feat;
                UCR_OFS_ENH: next_rdata = cf.enh;
                UCR_OFS_TXQ: next_rdata = st.tx_level;
                UCR_OFS_RXQ: next_rdata = st.rx_level;
                UCR_OFS_FLOW: begin
                    next_rdata = UCR_ZERO8;
                    next_rdata[UCR_FLOW_RESUME] = resume_flag[c];
                    next_rdata[UCR_FLOW_PAUSE] = pause_flag[c];
                end
                default: next_rdata = UCR_ZERO8;
            endcase
        end
    end

    // scratch words gathered for the read mux
    logic [CHANNELS-1:0][7:0] scr_all;
    for (genvar s = 0; s < CHANNELS; s++) begin : g_scr
        assign scr_all[s] = g_ch[s].scratch;
    end


    function automatic logic [7:0] g_scr_rd(input int idx);
        g_scr_rd = scr_all[idx];
    endfunction

    // registered read answer, one cycle after the request
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rdata <= UCR_ZERO8;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req_in.rd;
            if (req_in.rd) begin
                rdata <= next_rdata;
            end
        end
    end

    // follows every write; only meaningful alongside tx_push
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            tx_data <= UCR_ZERO8;
        end else if (req_in.wr) begin
            tx_data <= req_in.wdata;
        end
    end

    // no pin output exists for the general output bits
    assign rdata_out = rdata;
    assign rvalid_out = rvalid;
    assign tx_push_out = tx_push;
    assign rx_pop_out = rx_pop;
    assign tx_data_out = tx_data;
endmodule // ucr_bank

`default_nettype wire

// File: tb/ucr_bank_assertions.sv
// ucr_bank_assertions: port checks on ucr_bank, channel 0 plus read answers and writes to channels 4..7
// assumes it is bound into ucr_bank, ports as declared there
`timescale 1ns/1ns
`default_nettype none
module ucr_bank_assertions
    import ucr_pkg::*;
#(
    parameter int CHANNELS = UCR_CHANNELS
) (
    // clock, reset, host port
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire ucr_req_t req_in,
    input wire logic [7:0] rdata_out,
    input wire logic rvalid_out,
    // core side
    input wire ucr_cfg_t [CHANNELS-1:0] cfg_out,
    input wire logic [CHANNELS-1:0] tx_push_out,
    input wire logic [CHANNELS-1:0] rx_pop_out,
    input wire logic [7:0] tx_data_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic wr0, rd0, hold, dl;
    logic [3:0] ofs, dly;
    assign wr0 = req_in.wr && req_in.addr[11:9] == 3'h0;
    assign rd0 = req_in.rd && req_in.addr[11:9] == 3'h0;
    assign ofs = req_in.addr[3:0];
    assign hold = ofs == UCR_OFS_HOLD;
    assign dl = cfg_out[0].lctl[UCR_LCTL_DIVEN];
    assign dly = req_in.wdata[7:4];
    property p_ans; req_in.rd |=> rvalid_out; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_ext; !cfg_out[0].enh[UCR_ENH_EXTEN] |-> ((cfg_out[0].ien & UCR_IEN_EXT_MASK)
        | (cfg_out[0].mctl & UCR_MCTL_EXT_MASK)) == 8'h00; endproperty
    a_ext: assert property (p_ext) else $error("ext bits live");
    property p_push; wr0 && hold && !dl |=> tx_push_out[0] && tx_data_out == $past(req_in.wdata);
    endproperty
    a_push: assert property (p_push) else $error("no push");
    property p_div; wr0 && hold && dl |=> !tx_push_out[0]
        && cfg_out[0].divisor[7:0] == $past(req_in.wdata); endproperty
    a_div: assert property (p_div) else $error("divisor miss");
    property p_pop; rd0 && hold && !dl |=> rx_pop_out[0]; endproperty
    a_pop: assert property (p_pop) else $error("no pop");
    property p_flow; rd0 && ofs == UCR_OFS_FLOW |=> rdata_out[7:2] == 6'h00; endproperty
    a_flow: assert property (p_flow) else $error("flag upper bits");
    property p_dly; wr0 && ofs == UCR_OFS_MSTAT |=> cfg_out[0].turnaround == $past(dly); endproperty
    a_dly: assert property (p_dly) else $error("delay miss");
    property p_chan; req_in.wr && req_in.addr[11] |=> $stable(cfg_out); endproperty
    a_chan: assert property (p_chan) else $error("bad channel wrote");
endmodule // ucr_bank_assertions
bind ucr_bank ucr_bank_assertions #(.CHANNELS(CHANNELS)) i_chk (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .req_in(req_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .cfg_out(cfg_out), .tx_push_out(tx_push_out), .rx_pop_out(rx_pop_out),
    .tx_data_out(tx_data_out));
`default_nettype wire

// File: tb/ucr_core_model.sv
// ucr_core_model: status source for four serial cores
// assumes bench gives a base byte and one-cycle flow pulses
`timescale 1ns/1ns
`default_nettype none
module ucr_core_model
    import ucr_pkg::*;
(
    // clock and bench control
    input wire logic clk_sys_in,
    input wire logic [7:0] base_in,
    input wire logic [3:0] res_in,
    input wire logic [3:0] pau_in,
    // status to the bank
    output var ucr_stat_t [3:0] stat_out
);
    // xor, not add, so no carry spills between fields
    always_ff @(posedge clk_sys_in) begin
        for (int c = 0; c < 4; c++) begin
            stat_out[c] <= {{6{base_in ^ 8'(c << 4)}} ^ 48'h0001_0203_0405, res_in[c], pau_in[c]};
        end
    end
endmodule // ucr_core_model
`default_nettype wire

// File: tb/uart_channel_register_map_bench.sv
// uart_channel_register_map_bench: self-checking bench for ucr_bank
// assumes ucr_pkg, ucr_bank, checker and ucr_core_model compiled first
`timescale 1ns/1ns
`default_nettype none
module uart_channel_register_map_bench;
    import ucr_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    ucr_req_t req = '0;
    logic [7:0] rdata, txd;
    logic [7:0] base = 8'h00;
    logic rvalid;
    logic [3:0] res = 4'h0, pau = 4'h0, push, pop;
    ucr_stat_t [3:0] stat;
    ucr_cfg_t [3:0] cfg;
    int num_errors = 0, compares = 0, seed = 86;
    int m[4][18];
    int fl[4];
    ucr_bank i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_in(req), .rdata_out(rdata),
        .rvalid_out(rvalid), .stat_in(stat), .cfg_out(cfg), .tx_push_out(push),
        .rx_pop_out(pop), .tx_data_out(txd));
    ucr_core_model i_core (.clk_sys_in(clk_sys_in), .base_in(base), .res_in(res),
        .pau_in(pau), .stat_out(stat));
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input logic [7:0] got, input int exp);
        compares++;
        if (got !== 8'(exp)) begin
            num_errors++;
            $display("Error %0t: got %h want %h", $time, got, 8'(exp));
        end
    endtask
    task automatic close_out();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    function automatic int exp_rd(int c, int o);
        int b;
        int e;
        if (c > 3) return 0;
        b = base ^ (c << 4);
        e = m[c][9] & 8'h10;
        case (o)
            0: return m[c][3][7] ? m[c][16] : b;
            1: return m[c][3][7] ? m[c][17] : m[c][1];
            2: return (b ^ 1) & (e ? 8'hff : 8'hcf);
            5: return b ^ 2;
            6: return (b ^ 3) & (e ? 8'hff : 8'h0f);
            10: return b ^ 4;
            11: return b ^ 5;
            12: return fl[c];
            default: return m[c][o];
        endcase
    endfunction
    task automatic wr(input int c, input int o, input logic [7:0] d);
        int e;
        @(posedge clk_sys_in);
        req <= '{rd: 1'b0, wr: 1'b1, addr: 12'(c * 512 + o), wdata: d};
        @(posedge clk_sys_in);
        req.wr <= 1'b0;
        #1;
        if (c < 4) begin
            e = m[c][9] & 8'h10;
            case (o)
                0: if (m[c][3][7]) m[c][16] = d;
                   else begin
                       chk(push, 1 << c);
                       chk(txd, d);
                   end
                1: if (m[c][3][7]) m[c][17] = d;
                   else m[c][1] = e ? d & 8'hef : d & 8'h0f;
                2: chk(cfg[c].qctl, e ? d : d & 8'hcf);
                4: m[c][4] = e ? d : (m[c][4] & 8'he4) | (d & 8'h1b);
                6: chk(cfg[c].turnaround, d[7:4]);
                3, 7, 8, 9: m[c][o] = d;
                default: ;
            endcase
        end
    endtask
    task automatic rd(input int c, input int o);
        int i;
        int x;
        x = exp_rd(c, o);
        @(posedge clk_sys_in);
        req <= '{rd: 1'b1, wr: 1'b0, addr: 12'(c * 512 + o), wdata: 8'h00};
        @(posedge clk_sys_in);
        req.rd <= 1'b0;
        #1;
        for (i = 0; i < 4 && rvalid !== 1'b1; i++) #10;
        if (i == 4) begin
            num_errors++;
            $display("Error %0t: read never answered", $time);
            close_out();
        end
        chk(rdata, x);
        if (o == 0 && c < 4 && !m[c][3][7]) chk(pop, 1 << c);
        if (o == 12 && c < 4) fl[c] = 0;
    endtask
    task automatic flag(input int c, input int k);
        @(posedge clk_sys_in);
        res <= 4'((k >> 1) << c);
        pau <= 4'((k & 1) << c);
        @(posedge clk_sys_in);
        res <= 4'h0;
        pau <= 4'h0;
        fl[c] |= k;
    endtask
    initial begin
        int c, o, e;
        logic [7:0] d;
        repeat (12) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        base <= 8'($random(seed));
        // plain set first, so dropped ext bits stay zero either way
        for (e = 0; e < 2; e++) begin
            for (c = 0; c < 5; c++) begin
                wr(c, 9, 8'(e << 4));
                for (o = 0; o < 9; o++) begin
                    d = $random(seed);
                    wr(c, o, o == 3 ? d & 8'h7f : d);
                end
                for (o = 0; o < 13; o++) rd(c, o);
            end
            $display("test registers enh %0d done", e);
        end
        for (c = 0; c < 4; c++) begin
            wr(c, 3, 8'h80);
            wr(c, 0, 8'($random(seed)));
            wr(c, 1, 8'($random(seed)));
            rd(c, 0);
            rd(c, 1);
            chk(cfg[c].divisor[15:8], m[c][17]);
            chk(cfg[c].divisor[7:0], m[c][16]);
            wr(c, 3, 8'h03);
            rd(c, 1);
        end
        $display("test divisor done");
        for (c = 0; c < 4; c++) begin
            for (e = 1; e < 4; e++) begin
                flag(c, e);
                rd(c, 12);
                rd(c, 12);
            end
        end
        $display("test flags done");
        close_out();
    end
endmodule // uart_channel_register_map_bench
`default_nettype wire
